// file: shared/adcprt_params.svh
// adcprt constants: register offsets, field positions, reset values, widths
`ifndef ADCPRT_PARAMS_SVH
`define ADCPRT_PARAMS_SVH

`define ADCPRT_DATA_W       14
`define ADCPRT_PIPE_W       15
`define ADCPRT_LAT_WHOLE    9
`define ADCPRT_PIPE_DEPTH   10

`define ADCPRT_SEL_RESULT   2'h0
`define ADCPRT_SEL_GAIN     2'h1
`define ADCPRT_SEL_OFFSET   2'h2
`define ADCPRT_SEL_CONTROL  2'h3

`define ADCPRT_GAIN_MASK    14'h0007
`define ADCPRT_OFFS_MASK    14'h00FF
`define ADCPRT_CTRL_MASK    14'h3FC0
`define ADCPRT_GAIN_RST     14'h0000
`define ADCPRT_OFFS_RST     14'h0000
`define ADCPRT_CTRL_RST     14'h0000

`define ADCPRT_CTL_PWD      13
`define ADCPRT_CTL_REF      12
`define ADCPRT_CTL_FMT      11
`define ADCPRT_CTL_TM_HI    10
`define ADCPRT_CTL_TM_LO    8
`define ADCPRT_CTL_OFFDIS   7

`define ADCPRT_OFFS_MSB     7
`define ADCPRT_CODE_MAX     16'sh3FFF

`define ADCPRT_PIN_W        20
`define ADCPRT_PIN_DIN_HI   13
`define ADCPRT_PIN_SEL_LO   14
`define ADCPRT_PIN_SEL_HI   15
`define ADCPRT_PIN_WE       16
`define ADCPRT_PIN_OE       17
`define ADCPRT_PIN_CS       18
`define ADCPRT_PIN_CONV     19
`define ADCPRT_PIN_RST      20'h7FFFF

`endif

// file: shared/adcprt_pkg.sv
// adcprt types, reset images and shared code arithmetic
`include "adcprt_params.svh"
package adcprt_pkg;

  typedef logic [`ADCPRT_DATA_W-1:0] adcprt_word_t;
  typedef logic [`ADCPRT_PIPE_W-1:0] adcprt_pipe_word_t;

  typedef struct packed {
    logic [`ADCPRT_PIN_W-1:0] pin_m;
    logic [`ADCPRT_PIN_W-1:0] pin_s;
    logic                     conv_p;
    logic                     we_p;
    logic                     fall_p;
    adcprt_word_t             gain_q;
    adcprt_word_t             offs_q;
    adcprt_word_t             ctrl_q;
    adcprt_word_t             result_q;
    adcprt_word_t             dout_q;
    logic                     ov_q;
    logic                     doe_n_q;
  } adcprt_port_st_t;

  typedef struct packed {
    logic [`ADCPRT_PIPE_DEPTH-1:0][`ADCPRT_PIPE_W-1:0] mem;
    adcprt_pipe_word_t                                 rd_q;
  } adcprt_pipe_st_t;

  localparam adcprt_port_st_t ADCPRT_PORT_RST = '{
    pin_m:    `ADCPRT_PIN_RST,
    pin_s:    `ADCPRT_PIN_RST,
    conv_p:   1'b0,
    we_p:     1'b1,
    fall_p:   1'b0,
    gain_q:   `ADCPRT_GAIN_RST,
    offs_q:   `ADCPRT_OFFS_RST,
    ctrl_q:   `ADCPRT_CTRL_RST,
    result_q: '0,
    dout_q:   '0,
    ov_q:     1'b0,
    doe_n_q:  1'b1
  };

  // straight-binary code plus signed offset, clamped to the code range
  function automatic adcprt_word_t adcprt_sat_add(
    input adcprt_word_t code,
    input logic [7:0]   offs
  );
    logic signed [15:0] sum;
    sum = $signed({2'h0, code}) + $signed({{8{offs[7]}}, offs});
    if (sum < 16'sh0000) begin
      return '0;
    end else if (sum > `ADCPRT_CODE_MAX) begin
      return 14'h3FFF;
    end
    return sum[13:0];
  endfunction : adcprt_sat_add

  // two's complement is straight binary with the top bit inverted
  function automatic adcprt_word_t adcprt_fmt(
    input adcprt_word_t code,
    input logic         twos
  );
    return twos ? {~code[13], code[12:0]} : code;
  endfunction : adcprt_fmt

endpackage : adcprt_pkg

// file: verilog/adcprt_delay.sv
// adcprt sample pipeline: shift on sample clock rise, registered read
`timescale 1ns/10ps
`default_nettype none
`include "adcprt_params.svh"
module adcprt_delay
  import adcprt_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic              wr_en,
  input  wire adcprt_pipe_word_t wr_data,
  input  wire logic              rd_en,
  output adcprt_pipe_word_t      rd_data
);

  adcprt_pipe_st_t st_q;
  adcprt_pipe_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (ce && wr_en) begin
      st_d.mem = {st_q.mem[`ADCPRT_PIPE_DEPTH-2:0], wr_data};
    end
    if (ce && rd_en) begin
      st_d.rd_q = st_q.mem[`ADCPRT_PIPE_DEPTH-1];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rd_q;

  AST_PIPE_READ: assert property (@(posedge clk) disable iff (!nrst)
    ce && rd_en |=> rd_data == $past(st_q.mem[`ADCPRT_PIPE_DEPTH-1]))
    else $error("pipeline read does not return the oldest stage");

endmodule : adcprt_delay
`default_nettype wire

// file: verilog/adcprt_port.sv
// adcprt parallel register port of a pipelined 14-bit converter
`timescale 1ns/10ps
`default_nettype none
`include "adcprt_params.svh"
module adcprt_port
  import adcprt_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         conv_clk,
  input  wire adcprt_word_t sample_code,
  input  wire logic         sample_over,
  input  wire logic         cs_n,
  input  wire logic         oe_n,
  input  wire logic         we_n,
  input  wire logic         reg_select_hi,
  input  wire logic         reg_select_lo,
  input  wire adcprt_word_t data_in,
  output adcprt_word_t      data_out,
  output logic              data_oe_n,
  output logic              over_range_flag,
  output logic              power_down_bit,
  output logic              ref_select,
  output logic [2:0]        gain_code,
  output logic [2:0]        test_mode_field
);

  adcprt_port_st_t   s_q;
  adcprt_port_st_t   s_d;
  adcprt_pipe_word_t pipe_rd;
  adcprt_word_t      din_s;
  adcprt_word_t      corr;
  logic [1:0]        sel_s;
  logic              conv_s;
  logic              we_s;
  logic              oe_s;
  logic              cs_s;
  logic              rise_evt;
  logic              fall_evt;
  logic              wr_evt;
  logic              off_dis;
  logic              twos;

  // only the second synchroniser stage is looked at
  assign din_s    = s_q.pin_s[`ADCPRT_PIN_DIN_HI:0];
  assign sel_s    = s_q.pin_s[`ADCPRT_PIN_SEL_HI:`ADCPRT_PIN_SEL_LO];
  assign conv_s   = s_q.pin_s[`ADCPRT_PIN_CONV];
  assign we_s     = s_q.pin_s[`ADCPRT_PIN_WE];
  assign oe_s     = s_q.pin_s[`ADCPRT_PIN_OE];
  assign cs_s     = s_q.pin_s[`ADCPRT_PIN_CS];
  assign rise_evt = conv_s && !s_q.conv_p;
  assign fall_evt = !conv_s && s_q.conv_p;
  assign wr_evt   = we_s && !s_q.we_p && !cs_s;
  assign off_dis  = s_q.ctrl_q[`ADCPRT_CTL_OFFDIS];
  assign twos     = s_q.ctrl_q[`ADCPRT_CTL_FMT];

  // raw core codes are straight binary; correction then formatting
  assign corr = off_dis ? pipe_rd[13:0]
              : adcprt_sat_add(pipe_rd[13:0],
                               s_q.offs_q[`ADCPRT_OFFS_MSB:0]);

  adcprt_delay u_pipe (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .wr_en   (rise_evt),
    .wr_data ({sample_over, sample_code}),
    .rd_en   (fall_evt),
    .rd_data (pipe_rd)
  );

  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.pin_m  = {conv_clk, cs_n, oe_n, we_n, reg_select_hi,
                    reg_select_lo, data_in};
      s_d.pin_s  = s_q.pin_m;
      s_d.conv_p = conv_s;
      s_d.we_p   = we_s;
      s_d.fall_p = fall_evt;
      if (wr_evt) begin
        unique case (sel_s)
          `ADCPRT_SEL_RESULT: begin
            s_d.gain_q = s_q.gain_q;
          end
          `ADCPRT_SEL_GAIN: begin
            s_d.gain_q = din_s & `ADCPRT_GAIN_MASK;
          end
          `ADCPRT_SEL_OFFSET: begin
            s_d.offs_q = din_s & `ADCPRT_OFFS_MASK;
          end
          `ADCPRT_SEL_CONTROL: begin
            s_d.ctrl_q = din_s & `ADCPRT_CTRL_MASK;
          end
        endcase
      end
      if (s_q.fall_p) begin
        s_d.result_q = adcprt_fmt(corr, twos);
        s_d.ov_q     = pipe_rd[`ADCPRT_PIPE_W-1];
      end
      unique case (sel_s)
        `ADCPRT_SEL_RESULT:  s_d.dout_q = s_q.result_q;
        `ADCPRT_SEL_GAIN:    s_d.dout_q = s_q.gain_q;
        `ADCPRT_SEL_OFFSET:  s_d.dout_q = s_q.offs_q;
        `ADCPRT_SEL_CONTROL: s_d.dout_q = s_q.ctrl_q;
      endcase
      s_d.doe_n_q = oe_s || cs_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= ADCPRT_PORT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_out        = s_q.dout_q;
  assign data_oe_n       = s_q.doe_n_q;
  assign over_range_flag = s_q.ov_q;
  assign power_down_bit  = s_q.ctrl_q[`ADCPRT_CTL_PWD];
  assign ref_select      = s_q.ctrl_q[`ADCPRT_CTL_REF];
  assign gain_code       = s_q.gain_q[2:0];
  assign test_mode_field = s_q.ctrl_q[`ADCPRT_CTL_TM_HI:`ADCPRT_CTL_TM_LO];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence wr_to(logic [1:0] a);
    ce && wr_evt && sel_s == a;
  endsequence

  sequence rd_of(logic [1:0] a);
    ce && !oe_s && !cs_s && sel_s == a;
  endsequence

  sequence sample_done;
    ce && s_q.fall_p;
  endsequence

  AST_DRIVE_ONLY_WHEN_ENABLED: assert property (
    !data_oe_n |-> $past(!oe_s && !cs_s))
    else $error("data bus driven without output enable");

  AST_RELEASE_ON_OE_HIGH: assert property (
    ce && oe_s |=> data_oe_n)
    else $error("data bus not released after output enable high");

  AST_READ_RESULT: assert property (
    rd_of(`ADCPRT_SEL_RESULT) |=> data_out == $past(s_q.result_q))
    else $error("address 0 read does not return the result");

  AST_READ_CONTROL: assert property (
    rd_of(`ADCPRT_SEL_CONTROL) |=> data_out == $past(s_q.ctrl_q))
    else $error("address 3 read does not return control");

  AST_WRITE_GAIN: assert property (
    wr_to(`ADCPRT_SEL_GAIN) |=> gain_code == $past(din_s[2:0])
      && s_q.gain_q[13:3] == '0)
    else $error("gain write not stored as 3-bit code");

  AST_WRITE_OFFSET_THEN_READ: assert property (
    wr_to(`ADCPRT_SEL_OFFSET) ##1 rd_of(`ADCPRT_SEL_OFFSET)
      |=> data_out == {6'h00, $past(din_s[7:0], 2)})
    else $error("offset write not read back");

  AST_RESULT_WRITE_IGNORED: assert property (
    wr_to(`ADCPRT_SEL_RESULT) |=> $stable(s_q.gain_q)
      && $stable(s_q.offs_q) && $stable(s_q.ctrl_q))
    else $error("write to result address changed a register");

  AST_FORMAT_BYPASS: assert property (
    sample_done and (off_dis && twos) |=>
      s_q.result_q == $past({~pipe_rd[13], pipe_rd[12:0]}))
    else $error("two's complement output wrong with correction off");

  AST_OFFSET_APPLIED: assert property (
    sample_done and (!off_dis && !twos) |=> s_q.result_q ==
      $past(adcprt_sat_add(pipe_rd[13:0], s_q.offs_q[7:0])))
    else $error("offset not added to straight binary result");

  AST_OVER_RANGE_PIPE: assert property (
    sample_done |=> over_range_flag == $past(pipe_rd[14]))
    else $error("over-range flag not aligned with data");

  AST_RESET_VALUES: assert property (
    $rose(nrst) |-> s_q.gain_q == '0 && s_q.offs_q == '0
      && s_q.ctrl_q == '0 && data_oe_n)
    else $error("registers not cleared by reset");

endmodule : adcprt_port
`default_nettype wire

// file: test/adcprt_host.sv
// host-side bus model driving the register port pins
`timescale 1ns/10ps
`default_nettype none
module adcprt_host
  import adcprt_pkg::*;
(
  input  wire logic         clk,
  input  wire adcprt_word_t bus,
  output logic              cs_n,
  output logic              oe_n,
  output logic              we_n,
  output logic              sel_hi,
  output logic              sel_lo,
  output adcprt_word_t      data_in
);
  initial begin
    {cs_n, oe_n, we_n, sel_hi, sel_lo} = 5'h1F;
    data_in = 14'h0000;
  end
  // released data lines show the inverse of the last word
  task automatic wr(input logic [1:0] sel, input adcprt_word_t d,
                    input logic csn);
    @(posedge clk);
    cs_n <= csn;
    {sel_hi, sel_lo} <= sel;
    data_in <= d;
    we_n <= 1'b0;
    repeat (4) @(posedge clk);
    we_n <= 1'b1;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    data_in <= ~d;
    repeat (4) @(posedge clk);
  endtask : wr
  task automatic open_rd(input logic [1:0] sel);
    @(posedge clk);
    cs_n <= 1'b0;
    oe_n <= 1'b0;
    {sel_hi, sel_lo} <= sel;
    repeat (6) @(posedge clk);
  endtask : open_rd
  task automatic close_rd();
    @(posedge clk);
    cs_n <= 1'b1;
    oe_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : close_rd
  task automatic rd(input logic [1:0] sel, output adcprt_word_t d);
    open_rd(sel);
    #1 d = bus;
    close_rd();
  endtask : rd
endmodule : adcprt_host
`default_nettype wire

// file: test/adcprt_port_tb.sv
// self-checking bench for the converter register port
`timescale 1ns/10ps
`default_nettype none
module adcprt_port_tb
  import adcprt_pkg::*;
;
  typedef struct packed {
    adcprt_word_t ctrl;
    logic [7:0]   offs;
    adcprt_word_t raw;
    logic         ov;
    adcprt_word_t exp;
  } adcprt_row_t;
  adcprt_row_t rows [9] = '{
    '{14'h0000, 8'h00, 14'h2000, 1'b0, 14'h2000},
    '{14'h0800, 8'h00, 14'h2000, 1'b0, 14'h0000},
    '{14'h0800, 8'h00, 14'h0000, 1'b1, 14'h2000},
    '{14'h0800, 8'h00, 14'h3FFF, 1'b0, 14'h1FFF},
    '{14'h0000, 8'h05, 14'h1000, 1'b0, 14'h1005},
    '{14'h0000, 8'h80, 14'h0010, 1'b1, 14'h0000},
    '{14'h0080, 8'h80, 14'h0010, 1'b0, 14'h0010},
    '{14'h0880, 8'h80, 14'h0010, 1'b0, 14'h2010},
    '{14'h0000, 8'h7F, 14'h3FF0, 1'b0, 14'h3FFF}};
  logic         clk;
  logic         nrst;
  logic         ce;
  logic         conv_clk;
  adcprt_word_t sample_code;
  logic         sample_over;
  logic         cs_n, oe_n, we_n, sel_hi, sel_lo;
  adcprt_word_t data_in;
  adcprt_word_t data_out;
  logic         data_oe_n;
  logic         over_range_flag;
  logic         power_down_bit;
  logic         ref_select;
  logic [2:0]   gain_code;
  logic [2:0]   test_mode_field;
  wire adcprt_word_t bus;
  int           mismatches = 0;
  int           n_checks = 0;

  assign bus = (data_oe_n === 1'b0) ? data_out : 'z;

  adcprt_port dut (
    .clk(clk), .nrst(nrst), .ce(ce), .conv_clk(conv_clk),
    .sample_code(sample_code), .sample_over(sample_over),
    .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .reg_select_hi(sel_hi), .reg_select_lo(sel_lo),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .over_range_flag(over_range_flag), .power_down_bit(power_down_bit),
    .ref_select(ref_select), .gain_code(gain_code),
    .test_mode_field(test_mode_field));

  adcprt_host host (
    .clk(clk), .bus(bus), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .sel_hi(sel_hi), .sel_lo(sel_lo), .data_in(data_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [13:0] seen,
                     input logic [13:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one sample period: 10 clk high, 10 clk low
  task automatic conv(input adcprt_word_t code, input logic ov);
    @(posedge clk);
    conv_clk <= 1'b1;
    sample_code <= code;
    sample_over <= ov;
    repeat (10) @(posedge clk);
    conv_clk <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
  endtask : conv

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    adcprt_word_t v;
    nrst = 1'b0;
    ce = 1'b1;
    conv_clk = 1'b0;
    sample_code = 14'h0000;
    sample_over = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("bus idle", data_oe_n, 14'h0001);
    foreach (rows[i]) begin
      host.wr(2'h3, rows[i].ctrl, 1'b0);
      host.wr(2'h2, {6'h00, rows[i].offs}, 1'b0);
      host.open_rd(2'h0);
      repeat (10) conv(rows[i].raw, rows[i].ov);
      chk("result", bus, rows[i].exp);
      chk("over", over_range_flag, rows[i].ov);
      host.close_rd();
    end
    host.wr(2'h1, 14'h3FFD, 1'b0);
    host.rd(2'h1, v);
    chk("gain", v, 14'h0005);
    chk("gain_code", gain_code, 14'h0005);
    host.wr(2'h2, 14'h3F80, 1'b0);
    host.rd(2'h2, v);
    chk("offset", v, 14'h0080);
    // write while the same register is being read
    host.open_rd(2'h2);
    host.wr(2'h2, 14'h0033, 1'b0);
    host.close_rd();
    host.rd(2'h2, v);
    chk("offset under read", v, 14'h0033);
    host.wr(2'h3, 14'h3FFF, 1'b0);
    host.rd(2'h3, v);
    chk("control", v, 14'h3FC0);
    chk("ctrl pins", {power_down_bit, ref_select, test_mode_field},
        14'h001F);
    host.wr(2'h0, 14'h1555, 1'b0);
    host.wr(2'h1, 14'h0002, 1'b1);
    host.rd(2'h1, v);
    chk("gain kept", v, 14'h0005);
    // clock enable low: a full write strobe must leave no trace
    ce <= 1'b0;
    host.wr(2'h1, 14'h0002, 1'b0);
    ce <= 1'b1;
    host.rd(2'h1, v);
    chk("gain frozen", v, 14'h0005);
    host.wr(2'h3, 14'h0000, 1'b0);
    host.wr(2'h2, 14'h0000, 1'b0);
    host.open_rd(2'h0);
    repeat (10) conv(14'h1234, 1'b0);
    for (int i = 0; i < 11; i++) begin
      conv((i == 0) ? 14'h2ABC : 14'h1234, i == 0);
      chk("latency", bus, (i == 9) ? 14'h2ABC : 14'h1234);
      chk("over delay", over_range_flag, {13'h0000, i == 9});
    end
    host.close_rd();
    #1 chk("released", data_oe_n, 14'h0001);
    host.wr(2'h2, 14'h0011, 1'b0);
    host.wr(2'h3, 14'h0800, 1'b0);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      host.rd(s[1:0], v);
      chk("reset value", v, 14'h0000);
    end
    give_verdict();
  end
endmodule : adcprt_port_tb
`default_nettype wire
